// ===== design/mod_consts.svh
// Constants for the multiply to odd register decoder.
// Assumes inclusion by bare name from the decoder module.
`ifndef MOD_CONSTS_SVH
`define MOD_CONSTS_SVH
// Fixed high-halfword bits 15:9 of the group.
`define MOD_HI_TOP_VAL    7'h60
// Fixed high-halfword bits 6 and 3.
`define MOD_HI_B6_VAL     1'h0
`define MOD_HI_B3_VAL     1'h1
// Operation codes in high-halfword bits 2:0.
`define MOD_OP_ASSIGN     3'h0
`define MOD_OP_ACC        3'h1
`define MOD_OP_SUB        3'h2
// Fixed low-halfword bits 13:9.
`define MOD_LO_FIX_VAL    5'h0C
// Parallel-issue marker bit in the full word.
`define MOD_PAR_BIT       27
// Operand-half select codes.
`define MOD_HALF_LL       2'h0
`define MOD_HALF_LH       2'h1
`define MOD_HALF_HL       2'h2
`define MOD_HALF_HH       2'h3
`endif

// ===== design/mod_pkg.sv
// Types shared by the multiply to odd register decoder.
// Assumes the constants header is on the include path.
package mod_pkg;
  // Operation applied to accumulator one.
  typedef enum logic [2:0] {
    MOD_OP_NONE_E   = 3'h0,
    MOD_OP_ASSIGN_E = 3'h1,
    MOD_OP_ACC_E    = 3'h2,
    MOD_OP_SUB_E    = 3'h4
  } mod_op_t;
  // Decoded fields travel together.
  typedef struct packed {
    logic        valid;
    logic        parallel;
    mod_op_t     op;
    logic        unsigned_fraction_option;
    logic        signed_integer_option;
    logic        scale_two_round_option;
    logic        integer_scale_saturate_option;
    logic        mixed_sign;
    logic        src0_high;
    logic        src1_high;
    logic [2:0]  dst;
    logic [2:0]  src0;
    logic [2:0]  src1;
  } mod_dec_t;
endpackage : mod_pkg

// ===== design/mod_decode.sv
// Decoder for 32-bit multiply forms that work on accumulator one into odd registers.
// Assumes opcodes arrive synchronous to ref_clk_i with a one-cycle valid strobe.
`timescale 1ns/1ps
`include "mod_consts.svh"
// Contract
// RL1 - high 0xC008 assigns product, writes odd
// RL2 - high 0xC009 accumulates product
// RL3 - high 0xC00A subtracts product
// RL4 - high bit 7 is unsigned fraction
// RL5 - high bit 8 alone is signed integer
// RL6 - high bit 5 alone is scale round
// RL7 - bits 8 and 5 together: integer saturate
// RL8 - high bit 4 is mixed sign modifier
// RL9 - mixed sign combines with integer saturate
// RL10 - low halfword fields and fixed 01100
// RL11 - half codes 00 and 01 meanings
// RL12 - half codes 10 and 11 meanings
// RL13 - parallel issue adds 0x0800_0000
// RL14 - first source left, second right
// RL15 - destination field names result register
// RL16 - nonmatching opcodes flagged foreign
module mod_decode (
  input  wire logic              ref_clk_i,   // Core clock.
  input  wire logic              srst_i,      // Synchronous reset, active high.
  input  wire logic              op_valid_i,  // Opcode strobe.
  input  wire logic [31:0]       opcode_i,    // Full opcode, high halfword first.
  output mod_pkg::mod_dec_t      dec_o,       // Registered decode result.
  output logic                   foreign_o    // Strobed opcode outside this group.
);

  // ****************************************************************
  // Field extraction
  // ****************************************************************
  // The decoder is purely a pattern match on one opcode word at a time.
  // It keeps no history between opcodes, so back-to-back issue is free.
  // The accumulator-zero and half-register forms share many bits with
  // this group; they differ in the low nibble of the high halfword and in
  // the fixed low-halfword bits, which is why both are checked here.
  // A limitation users must know: bit 11 of the high halfword is taken as
  // the parallel-issue marker and is never itself a reason to refuse.
  wire logic [15:0] hi_w = opcode_i[31:16];  // High halfword.
  wire logic [15:0] lo_w = opcode_i[15:0];   // Low halfword.
  // RL13 parallel marker
  wire logic        par_w = opcode_i[`MOD_PAR_BIT];
  // Bit 11 of the high halfword is masked out so parallel forms match too.
  wire logic [6:0]  top_w = {hi_w[15:12], 1'b0, hi_w[10:9]};
  // RL1 RL2 RL3 operation match
  wire logic        is_assign_w = (hi_w[2:0] == `MOD_OP_ASSIGN);
  wire logic        is_acc_w    = (hi_w[2:0] == `MOD_OP_ACC);
  wire logic        is_sub_w    = (hi_w[2:0] == `MOD_OP_SUB);
  // RL16 fixed bit check
  wire logic        fix_ok_w = (top_w == `MOD_HI_TOP_VAL) && (hi_w[6] == `MOD_HI_B6_VAL)
                              && (hi_w[3] == `MOD_HI_B3_VAL)
                              // RL10 low fixed bits
                              && (lo_w[13:9] == `MOD_LO_FIX_VAL);
  wire logic        match_w = fix_ok_w && (is_assign_w || is_acc_w || is_sub_w);
  // RL5 RL6 RL7 options; bits 8 and 5 together mean saturate, not either alone.
  wire logic        b8_w = hi_w[8];
  wire logic        b5_w = hi_w[5];
  // RL11 RL12 half select
  wire logic [1:0]  half_w = lo_w[15:14];

  // Combine everything into the struct; invalid opcodes carry cleared fields.
  mod_pkg::mod_dec_t dec_nxt;
  always_comb begin
    dec_nxt = '0;
    if (op_valid_i && match_w) begin
      dec_nxt.valid    = 1'b1;
      dec_nxt.parallel = par_w;
      dec_nxt.op       = is_assign_w ? mod_pkg::MOD_OP_ASSIGN_E :
                         is_acc_w    ? mod_pkg::MOD_OP_ACC_E : mod_pkg::MOD_OP_SUB_E;
      // RL4 unsigned fraction
      dec_nxt.unsigned_fraction_option     = hi_w[7];
      dec_nxt.signed_integer_option        = b8_w && !b5_w;
      dec_nxt.scale_two_round_option       = b5_w && !b8_w;
      dec_nxt.integer_scale_saturate_option = b8_w && b5_w;
      // RL8 RL9 mixed sign
      dec_nxt.mixed_sign = hi_w[4];
      // RL11 RL12 half decode
      dec_nxt.src0_high = (half_w == `MOD_HALF_HL) || (half_w == `MOD_HALF_HH);
      dec_nxt.src1_high = (half_w == `MOD_HALF_LH) || (half_w == `MOD_HALF_HH);
      // RL15 destination
      dec_nxt.dst  = lo_w[8:6];
      // RL14 source order
      dec_nxt.src0 = lo_w[5:3];
      dec_nxt.src1 = lo_w[2:0];
    end
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  // One cycle of latency keeps outputs straight from flip-flops.
  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      dec_o     <= '0;
      foreign_o <= 1'b0;
    end else begin
      dec_o     <= dec_nxt;
      // RL16 foreign flag
      foreign_o <= op_valid_i && !match_w;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // All checks sample on the core clock; all but reset_clr_a sleep while reset is held.
  // The strobed checks look at the registered outputs one cycle after the strobe,
  // which is exactly the single cycle of latency that the output stage adds.
  // Checks on reset itself override the default disable on purpose.
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  // Reset clears every output in the following cycle.
  reset_clr_a: assert property (disable iff (1'b0) srst_i
      |=> dec_o == '0 && !foreign_o) else $error("reset clear");
  // RL4 unsigned fraction option
  ufrac_opt_a: assert property (op_valid_i && match_w
      |=> dec_o.unsigned_fraction_option == $past(hi_w[7])) // RL4
      else $error("unsigned fraction wrong");
  // RL5 signed integer alone
  sint_opt_a: assert property (op_valid_i && match_w && hi_w[8] && !hi_w[5]
      |=> dec_o.signed_integer_option && !dec_o.integer_scale_saturate_option) // RL5
      else $error("signed integer wrong");
  // RL6 scale round alone
  srnd_opt_a: assert property (op_valid_i && match_w && hi_w[5] && !hi_w[8]
      |=> dec_o.scale_two_round_option && !dec_o.integer_scale_saturate_option) // RL6
      else $error("scale round wrong");
  // RL8 mixed sign modifier
  mixed_opt_a: assert property (op_valid_i && match_w
      |=> dec_o.mixed_sign == $past(hi_w[4])) // RL8
      else $error("mixed sign wrong");
  // RL11 low low halves
  half_ll_a: assert property (op_valid_i && match_w && half_w == 2'h0
      |=> !dec_o.src0_high && !dec_o.src1_high) // RL11
      else $error("half low low");
  // RL11 low high halves
  half_lh_a: assert property (op_valid_i && match_w && half_w == 2'h1
      |=> !dec_o.src0_high && dec_o.src1_high) // RL11
      else $error("half low high");
  // RL12 high low halves
  half_hl_a: assert property (op_valid_i && match_w && half_w == 2'h2
      |=> dec_o.src0_high && !dec_o.src1_high) // RL12
      else $error("half high low");
  // RL14 first source field
  src_left_a: assert property (op_valid_i && match_w
      |=> dec_o.src0 == $past(lo_w[5:3])) // RL14
      else $error("first source wrong");
  // RL16 idle cycle clears
  idle_clr_a: assert property (!op_valid_i
      |=> !dec_o.valid && !foreign_o) // RL16
      else $error("idle not clear");
  // RL16 valid and foreign exclusive
  excl_flag_a: assert property (!(dec_o.valid && foreign_o)) // RL16
      else $error("both flags high");
  // RL16 operation nibble three refused
  bad_op_a: assert property (op_valid_i && hi_w[2:0] == 3'h3
      |=> foreign_o && !dec_o.valid) // RL16
      else $error("bad operation taken");

  // RL1 assign decode
  assign_dec_a: assert property (op_valid_i && opcode_i == 32'hC0081800
      |=> dec_o.valid && dec_o.op == mod_pkg::MOD_OP_ASSIGN_E) else $error("assign missed");
  // RL2 accumulate decode
  acc_dec_a: assert property (op_valid_i && opcode_i[31:16] == 16'hC009 && lo_w[13:9] == 5'h0C
      |=> dec_o.op == mod_pkg::MOD_OP_ACC_E) else $error("accumulate missed");
  // RL3 subtract decode
  sub_dec_a: assert property (op_valid_i && opcode_i[31:16] == 16'hC00A && lo_w[13:9] == 5'h0C
      |=> dec_o.op == mod_pkg::MOD_OP_SUB_E) else $error("subtract missed");
  // RL7 saturate exclusive
  sat_excl_a: assert property (dec_o.integer_scale_saturate_option
      |-> !dec_o.signed_integer_option && !dec_o.scale_two_round_option)
      else $error("options overlap");
  // RL9 mixed saturate
  mix_sat_a: assert property (op_valid_i && opcode_i == 32'hC1391800
      |=> dec_o.mixed_sign && dec_o.integer_scale_saturate_option) else $error("mixed sat");
  // RL10 field extract
  field_ext_a: assert property (op_valid_i && match_w
      |=> dec_o.dst == $past(lo_w[8:6]) && dec_o.src1 == $past(lo_w[2:0]))
      else $error("fields wrong");
  // RL12 half high
  half_hh_a: assert property (op_valid_i && match_w && half_w == 2'h3
      |=> dec_o.src0_high && dec_o.src1_high) else $error("half select");
  // RL13 parallel form
  par_form_a: assert property (op_valid_i && opcode_i == 32'hC8081800
      |=> dec_o.valid && dec_o.parallel) else $error("parallel missed");
  // RL16 foreign flag
  foreign_a: assert property (op_valid_i && lo_w[13:9] != 5'h0C
      |=> foreign_o && !dec_o.valid) else $error("foreign missed");

  assign_cov_c: cover property (op_valid_i && match_w && is_assign_w);
  acc_cov_c:    cover property (op_valid_i && match_w && is_acc_w && hi_w[4]);
  par_cov_c:    cover property (op_valid_i && match_w && par_w);
  foreign_cov_c: cover property (foreign_o);
  sub_sat_cov_c: cover property (op_valid_i && match_w && is_sub_w && b8_w && b5_w);

endmodule : mod_decode

// ===== tb/mod_issue.sv
// Issue pipeline stand-in that hands opcodes to the decoder.
// Assumes the bench sets its inputs just after each rising edge.
`timescale 1ns/1ps
module mod_issue (
  input  wire logic        send_i,     // Offer an opcode this cycle.
  input  wire logic [31:0] word_i,     // Opcode to offer.
  output logic             op_valid_o, // Strobe to the decoder.
  output logic [31:0]      opcode_o    // Opcode lines.
);
  // Idle lines carry the inverse, so a decoder that ignores the strobe shows up.
  assign op_valid_o = send_i;
  assign opcode_o   = send_i ? word_i : ~word_i;
endmodule : mod_issue

// ===== tb/mod_decode_tb.sv
// Self-checking bench for the multiply to odd register decoder.
// Assumes the package and the decoder are compiled first.
`timescale 1ns/1ps
module mod_decode_tb;
  logic              ref_clk_i = 1'b0; // Core clock, 20 ns period.
  logic              srst_i    = 1'b1; // Held for four cycles.
  logic              send      = 1'b0; // Opcode offered.
  logic [31:0]       word      = '0;   // Opcode value offered.
  logic              op_valid;         // Strobe from the model.
  logic              foreign;          // Foreign flag from the decoder.
  logic [31:0]       opcode;           // Opcode from the model.
  mod_pkg::mod_dec_t dec;              // Decoder result.
  mod_pkg::mod_dec_t exp_dec   = '0;   // Result due at the next check.
  logic              exp_for   = 1'b0; // Foreign flag due at the next check.
  int                fails = 0, checks_done = 0, cyc = 0, i;
  logic [31:0]       w;
  // Named encodings first, then parallel form and several foreign words.
  logic [31:0] corner [16] = '{32'hC0081800, 32'hC009D9FF, 32'hC00A5800, 32'hC0889800,
    32'hC1081800, 32'hC0281800, 32'hC1281800, 32'hC0181800, 32'hC1381800, 32'hC1391800,
    32'hC13A1800, 32'hC8081800, 32'hC00B1800, 32'hC0081A00, 32'hC0481800, 32'h00000000};
  always #10 ref_clk_i = ~ref_clk_i;
  mod_issue u_mod_issue (.send_i(send), .word_i(word), .op_valid_o(op_valid),
    .opcode_o(opcode));
  mod_decode u_mod_decode (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .op_valid_i(op_valid),
    .opcode_i(opcode), .dec_o(dec), .foreign_o(foreign));
  function automatic logic hit(input logic [31:0] x);
    return x[31:28] == 4'hC && x[26:25] == 2'h0 && !x[22] && x[19] &&
      x[18:16] < 3'h3 && x[13:9] == 5'h0C;
  endfunction : hit
  function automatic mod_pkg::mod_dec_t dec_of(input logic [31:0] x);
    mod_pkg::mod_op_t op;
    mod_pkg::mod_dec_t r;
    r = '0;
    op = x[18:16] == 3'h0 ? mod_pkg::MOD_OP_ASSIGN_E :
      (x[16] ? mod_pkg::MOD_OP_ACC_E : mod_pkg::MOD_OP_SUB_E);
    if (hit(x)) begin
      r.valid                         = 1'b1;
      r.parallel                      = x[27];
      r.op                            = op;
      r.unsigned_fraction_option      = x[23];
      r.signed_integer_option         = x[24] & ~x[21];
      r.scale_two_round_option        = x[21] & ~x[24];
      r.integer_scale_saturate_option = x[24] & x[21];
      r.mixed_sign                    = x[20];
      r.src0_high                     = x[15];
      r.src1_high                     = x[14];
      r.dst                           = x[8:6];
      r.src0                          = x[5:3];
      r.src1                          = x[2:0];
    end
    return r;
  endfunction : dec_of
  task automatic cmp_dec(input mod_pkg::mod_dec_t e);
    checks_done++;
    if (dec !== e) begin
      fails++;
      $display("unexpected dec_o expected %h seen %h", e, dec);
    end
  endtask : cmp_dec
  task automatic cmp_for(input logic e);
    checks_done++;
    if (foreign !== e) begin
      fails++;
      $display("unexpected foreign_o expected %b seen %b", e, foreign);
    end
  endtask : cmp_for
  // Checks the answer to the previous cycle, then offers the next one.
  task automatic step(input logic v, input logic [31:0] x);
    @(posedge ref_clk_i);
    #1;
    cmp_dec(exp_dec);
    cmp_for(exp_for);
    send = v;
    word = x;
    exp_dec = v ? dec_of(x) : '0;
    exp_for = v & ~hit(x);
  endtask : step
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  // Cuts a hang short; the run needs about 420 cycles.
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 1000) begin
      fails++;
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(37201));
    repeat (4) @(posedge ref_clk_i);
    #1 srst_i = 1'b0;
    // corner words back to back, including the parallel form.
    for (i = 0; i < 16; i++) step(1'b1, corner[i]);
    step(1'b0, 32'h0);
    $display("corner test done");
    // random words, half of them forced into the group.
    for (i = 0; i < 400; i++) begin
      w = $urandom;
      if ($urandom % 2) w = (w & 32'h09B0C1FF) | 32'hC0081800 | ((32'($urandom % 3)) << 16);
      step($urandom % 5 != 0, w);
    end
    step(1'b0, 32'h0);
    $display("random test done");
    report_and_stop();
  end
endmodule : mod_decode_tb
